/* core/ccsc_pkg.sv */
// package: register indices, field positions and reset values of the card status change block
package ccsc_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [5:0] CCSC_IDX_IRQ_CFG    = 6'h05;
    localparam logic [5:0] CCSC_IDX_IO_CTRL    = 6'h07;
    localparam logic [5:0] CCSC_IDX_WIN0_SL    = 6'h08;
    localparam logic [5:0] CCSC_IDX_WIN0_SH    = 6'h09;
    localparam logic [5:0] CCSC_IDX_WIN0_PL    = 6'h0A;
    localparam logic [5:0] CCSC_IDX_WIN0_PH    = 6'h0B;
    localparam logic [5:0] CCSC_IDX_WIN1_SL    = 6'h0C;
    localparam logic [5:0] CCSC_IDX_WIN1_SH    = 6'h0D;
    localparam logic [5:0] CCSC_IDX_WIN1_PL    = 6'h0E;
    localparam logic [5:0] CCSC_IDX_WIN1_PH    = 6'h0F;
    localparam logic [5:0] CCSC_IDX_EVT_STAT   = 6'h10;
    localparam logic [5:0] CCSC_IDX_EVT_MASK   = 6'h11;

    // window byte registers are contiguous from the first window index
    localparam logic [5:0] CCSC_IDX_WIN_BASE   = CCSC_IDX_WIN0_SL;
    localparam int         CCSC_WIN_BYTES      = 8;

    // status change configuration fields
    localparam int         CCSC_CFG_ROUTE_LSB  = 4;
    localparam int         CCSC_CFG_CD_EN      = 3;
    localparam int         CCSC_CFG_RDY_EN     = 2;
    localparam int         CCSC_CFG_BWARN_EN   = 1;
    localparam int         CCSC_CFG_BDEAD_EN   = 0;

    // io control fields
    localparam int         CCSC_IOC_MAP_EN     = 7;
    localparam int         CCSC_IOC_W0_WIDE    = 0;
    localparam int         CCSC_IOC_W1_WIDE    = 1;

    // card input vector positions
    localparam int         CCSC_PIN_CD1        = 0;
    localparam int         CCSC_PIN_CD2        = 1;
    localparam int         CCSC_PIN_RDY        = 2;
    localparam int         CCSC_PIN_BWARN      = 3;
    localparam int         CCSC_PIN_BDEAD      = 4;
    localparam int         CCSC_PINS           = 5;

    // reset values and the prime count at which edge detection starts
    localparam logic [7:0] CCSC_RST_BYTE       = 8'h00;
    localparam logic [3:0] CCSC_RST_EVT        = 4'h0;
    localparam logic [1:0] CCSC_PRIME_DONE     = 2'h3;

    typedef struct packed {
        logic [7:0]                  irq_cfg;
        logic [7:0]                  io_ctrl;
        logic [CCSC_WIN_BYTES-1:0][7:0] win;
        logic [3:0]                  evt_stat;
        logic [3:0]                  evt_mask;
        logic [CCSC_PINS-1:0]        sync1;
        logic [CCSC_PINS-1:0]        sync2;
        logic [CCSC_PINS-1:0]        prev;
        logic [1:0]                  prime;
        logic                        ack;
        logic [31:0]                 dat;
        logic                        irq;
        logic [3:0]                  route;
        logic                        io_hit;
        logic                        io_win;
        logic                        io_wide;
    } ccsc_state_t;

    typedef struct packed {
        logic                        req;
        logic [15:0]                 addr;
    } ccsc_io_req_t;

    typedef struct packed {
        logic                        hit;
        logic                        win;
        logic                        wide;
    } ccsc_io_rsp_t;

endpackage

/* core/ccsc_regs.sv */
// card status change interrupt configuration and io window registers behind a wishbone slave
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module ccsc_regs
    import ccsc_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    // wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // card status pins
    input  wire logic          card_detect_first_n,
    input  wire logic          card_detect_second_n,
    input  wire logic          card_ready,
    input  wire logic          card_batt_warn,
    input  wire logic          card_batt_dead,
    // status change interrupt
    output logic               csc_irq,
    output logic      [3:0]    interrupt_request_line,
    // host io lookup
    input  wire ccsc_io_req_t  io_req,
    output ccsc_io_rsp_t       io_rsp
);

    ccsc_state_t st_reg;
    ccsc_state_t st_next;

    logic [CCSC_PINS-1:0] pins;
    logic [1:0]           win_hit;
    logic [3:0]           evt;
    logic [3:0]           evt_en;
    logic                 req_new;
    logic                 wr_done;
    logic [5:0]           idx;

    assign pins = {card_batt_dead, card_batt_warn, card_ready, card_detect_second_n, card_detect_first_n};
    assign idx     = wb_adr_i[7:2];
    // a request is answered one cycle after it is raised
    assign req_new = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    // the write lands at the edge where the master sees ack
    assign wr_done = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & st_reg.ack;

    // edges seen on synchronised pins; held off until the pipeline is primed,
    // otherwise an absent card would look like a detect change after reset
    always_comb begin
        evt = 4'h0;
        if (st_reg.prime == CCSC_PRIME_DONE) begin
            evt[CCSC_CFG_CD_EN]    = (st_reg.sync2[CCSC_PIN_CD1] ^ st_reg.prev[CCSC_PIN_CD1])
                                   | (st_reg.sync2[CCSC_PIN_CD2] ^ st_reg.prev[CCSC_PIN_CD2]);
            evt[CCSC_CFG_RDY_EN]   = st_reg.sync2[CCSC_PIN_RDY] & ~st_reg.prev[CCSC_PIN_RDY];
            evt[CCSC_CFG_BWARN_EN] = st_reg.sync2[CCSC_PIN_BWARN] & ~st_reg.prev[CCSC_PIN_BWARN];
            evt[CCSC_CFG_BDEAD_EN] = st_reg.sync2[CCSC_PIN_BDEAD] & ~st_reg.prev[CCSC_PIN_BDEAD];
        end
    end

    // enable bits share the position of the event they gate
    assign evt_en = evt & st_reg.irq_cfg[3:0];

    // window compare, inclusive at both ends so start == stop gives one byte
    genvar w;
    generate
        for (w = 0; w < 2; w++) begin : g_win
            logic [15:0] start;
            logic [15:0] stop;
            assign start = {st_reg.win[4*w+1], st_reg.win[4*w]};
            assign stop  = {st_reg.win[4*w+3], st_reg.win[4*w+2]};
            assign win_hit[w] = io_req.req & st_reg.io_ctrl[CCSC_IOC_MAP_EN]
                              & (io_req.addr >= start) & (io_req.addr <= stop);
        end
    endgenerate

    always_comb begin
        st_next = st_reg;

        // two-stage synchroniser for card pins
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        st_next.prev  = st_reg.sync2;
        if (st_reg.prime != CCSC_PRIME_DONE) begin
            st_next.prime = st_reg.prime + 2'h1;
        end

        // bus answer
        st_next.ack = req_new;
        if (req_new) begin
            st_next.dat = 32'h0000_0000;
            unique case (idx)
                CCSC_IDX_IRQ_CFG:  st_next.dat[7:0] = st_reg.irq_cfg;
                CCSC_IDX_IO_CTRL:  st_next.dat[7:0] = st_reg.io_ctrl;
                CCSC_IDX_EVT_STAT: st_next.dat[3:0] = st_reg.evt_stat;
                CCSC_IDX_EVT_MASK: st_next.dat[3:0] = st_reg.evt_mask;
                default: begin
                    if (idx >= CCSC_IDX_WIN_BASE && idx <= CCSC_IDX_WIN1_PH) begin
                        st_next.dat[7:0] = st_reg.win[3'(idx - CCSC_IDX_WIN_BASE)];
                    end
                end
            endcase
        end

        // register writes; unmapped indices are acked and ignored
        if (wr_done) begin
            unique case (idx)
                CCSC_IDX_IRQ_CFG:  st_next.irq_cfg  = wb_dat_i[7:0];
                CCSC_IDX_IO_CTRL:  st_next.io_ctrl  = wb_dat_i[7:0];
                CCSC_IDX_EVT_MASK: st_next.evt_mask = wb_dat_i[3:0];
                default: begin
                    if (idx >= CCSC_IDX_WIN_BASE && idx <= CCSC_IDX_WIN1_PH) begin
                        st_next.win[3'(idx - CCSC_IDX_WIN_BASE)] = wb_dat_i[7:0];
                    end
                end
            endcase
        end

        // sticky status, write one to clear; a new event wins over the clear
        if (wr_done && idx == CCSC_IDX_EVT_STAT) begin
            st_next.evt_stat = st_reg.evt_stat & ~wb_dat_i[3:0];
        end
        st_next.evt_stat = st_next.evt_stat | evt_en;

        st_next.irq   = |(st_reg.evt_stat & st_reg.evt_mask);
        st_next.route = st_reg.irq_cfg[7:CCSC_CFG_ROUTE_LSB];

        // io lookup; window 0 has priority when both match
        st_next.io_hit  = |win_hit;
        st_next.io_win  = ~win_hit[0] & win_hit[1];
        // a miss reports no width, so a stale window setting never shows on a lookup
        st_next.io_wide = win_hit[0] ? st_reg.io_ctrl[CCSC_IOC_W0_WIDE]
                                     : win_hit[1] & st_reg.io_ctrl[CCSC_IOC_W1_WIDE];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg          <= '0;
            st_reg.irq_cfg  <= CCSC_RST_BYTE;
            st_reg.io_ctrl  <= CCSC_RST_BYTE;
            st_reg.evt_stat <= CCSC_RST_EVT;
            st_reg.evt_mask <= CCSC_RST_EVT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o               = st_reg.dat;
    assign wb_ack_o               = st_reg.ack;
    assign csc_irq                = st_reg.irq;
    assign interrupt_request_line = st_reg.route;
    assign io_rsp.hit             = st_reg.io_hit;
    assign io_rsp.win             = st_reg.io_win;
    assign io_rsp.wide            = st_reg.io_wide;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    logic [15:0] s0;
    logic [15:0] p0;
    logic [15:0] s1;
    logic [15:0] p1;
    assign s0 = {st_reg.win[1], st_reg.win[0]};
    assign p0 = {st_reg.win[3], st_reg.win[2]};
    assign s1 = {st_reg.win[5], st_reg.win[4]};
    assign p1 = {st_reg.win[7], st_reg.win[6]};

    ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle pulse after request");

    route_follow_a: assert property (wr_done && idx == CCSC_IDX_IRQ_CFG
        |-> ##2 interrupt_request_line == $past(wb_dat_i[7:4], 2))
        else $error("interrupt line select does not follow config write");

    cd_event_a: assert property (evt[CCSC_CFG_CD_EN] && st_reg.irq_cfg[CCSC_CFG_CD_EN]
        |=> st_reg.evt_stat[CCSC_CFG_CD_EN])
        else $error("card detect change not latched");

    cd_gated_a: assert property ($rose(st_reg.evt_stat[CCSC_CFG_CD_EN])
        |-> $past(st_reg.irq_cfg[CCSC_CFG_CD_EN] && evt[CCSC_CFG_CD_EN]))
        else $error("card detect status set while disabled");

    ready_gated_a: assert property ($rose(st_reg.evt_stat[CCSC_CFG_RDY_EN])
        |-> $past(st_reg.irq_cfg[CCSC_CFG_RDY_EN] && evt[CCSC_CFG_RDY_EN]))
        else $error("ready status set without enabled rising edge");

    warn_gated_a: assert property ($rose(st_reg.evt_stat[CCSC_CFG_BWARN_EN])
        |-> $past(st_reg.irq_cfg[CCSC_CFG_BWARN_EN] && evt[CCSC_CFG_BWARN_EN]))
        else $error("battery warning status set while disabled");

    dead_gated_a: assert property ($rose(st_reg.evt_stat[CCSC_CFG_BDEAD_EN])
        |-> $past(st_reg.irq_cfg[CCSC_CFG_BDEAD_EN] && evt[CCSC_CFG_BDEAD_EN]))
        else $error("battery dead status set while disabled");

    irq_level_a: assert property (csc_irq == $past(|(st_reg.evt_stat & st_reg.evt_mask)))
        else $error("interrupt output disagrees with masked status");

    io_disabled_a: assert property (!st_reg.io_ctrl[CCSC_IOC_MAP_EN] |=> !io_rsp.hit)
        else $error("io hit while mapping disabled");

    io_width_a: assert property (io_rsp.hit && !io_rsp.win
        |-> io_rsp.wide == $past(st_reg.io_ctrl[CCSC_IOC_W0_WIDE]))
        else $error("window 0 width does not follow io control");

    win0_start_a: assert property (io_req.req && st_reg.io_ctrl[CCSC_IOC_MAP_EN]
        && io_req.addr == s0 && s0 <= p0 |=> io_rsp.hit && !io_rsp.win)
        else $error("window 0 start address missed");

    win0_stop_a: assert property (io_req.req && st_reg.io_ctrl[CCSC_IOC_MAP_EN]
        && io_req.addr == p0 && s0 <= p0 |=> io_rsp.hit)
        else $error("window 0 stop address missed");

    win1_start_a: assert property (io_req.req && st_reg.io_ctrl[CCSC_IOC_MAP_EN]
        && io_req.addr == s1 && s1 <= p1 |=> io_rsp.hit)
        else $error("window 1 start address missed");

    win1_stop_a: assert property (io_req.req && st_reg.io_ctrl[CCSC_IOC_MAP_EN]
        && io_req.addr == p1 && s1 <= p1 |=> io_rsp.hit)
        else $error("window 1 stop address missed");

    one_byte_a: assert property (io_req.req && st_reg.io_ctrl[CCSC_IOC_MAP_EN] && s0 == p0
        && io_req.addr != s0 && (io_req.addr < s1 || io_req.addr > p1) |=> !io_rsp.hit)
        else $error("one byte window matched a neighbour address");

    below_start_a: assert property (io_req.req && io_req.addr < s0 && io_req.addr < s1
        |=> !io_rsp.hit)
        else $error("hit below both window starts");

    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o)
        else $error("ack without a request");

    rd_upper_a: assert property (wb_ack_o
        |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    rd_cfg_a: assert property (req_new && !wb_we_i && idx == CCSC_IDX_IRQ_CFG
        |=> wb_dat_o[7:0] == $past(st_reg.irq_cfg))
        else $error("config read data wrong");

    rd_unmapped_a: assert property (req_new && !wb_we_i && idx > CCSC_IDX_EVT_MASK
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped index read not zero");

    cfg_write_a: assert property (wr_done && idx == CCSC_IDX_IRQ_CFG
        |=> st_reg.irq_cfg == $past(wb_dat_i[7:0]))
        else $error("config write not stored");

    ioctrl_write_a: assert property (wr_done && idx == CCSC_IDX_IO_CTRL
        |=> st_reg.io_ctrl == $past(wb_dat_i[7:0]))
        else $error("io control write not stored");

    win_write_a: assert property (wr_done && idx == CCSC_IDX_WIN0_SL
        |=> st_reg.win[0] == $past(wb_dat_i[7:0]))
        else $error("window 0 start low write not stored");

    stat_clear_a: assert property (wr_done && idx == CCSC_IDX_EVT_STAT && evt_en == 4'h0
        |=> st_reg.evt_stat == ($past(st_reg.evt_stat) & ~$past(wb_dat_i[3:0])))
        else $error("status write one to clear failed");

    stat_sticky_a: assert property (!(wr_done && idx == CCSC_IDX_EVT_STAT)
        |=> (st_reg.evt_stat & $past(st_reg.evt_stat)) == $past(st_reg.evt_stat))
        else $error("status bit lost without a clear");

    set_wins_a: assert property (evt_en != 4'h0
        |=> (st_reg.evt_stat & $past(evt_en)) == $past(evt_en))
        else $error("event lost against a clear");

    cd_off_a: assert property (!st_reg.irq_cfg[CCSC_CFG_CD_EN] && !st_reg.evt_stat[CCSC_CFG_CD_EN]
        |=> !st_reg.evt_stat[CCSC_CFG_CD_EN])
        else $error("card detect status set while disabled");

    rdy_off_a: assert property (!st_reg.irq_cfg[CCSC_CFG_RDY_EN] && !st_reg.evt_stat[CCSC_CFG_RDY_EN]
        |=> !st_reg.evt_stat[CCSC_CFG_RDY_EN])
        else $error("ready status set while disabled");

    warn_off_a: assert property (!st_reg.irq_cfg[CCSC_CFG_BWARN_EN] && !st_reg.evt_stat[CCSC_CFG_BWARN_EN]
        |=> !st_reg.evt_stat[CCSC_CFG_BWARN_EN])
        else $error("battery warning status set while disabled");

    dead_off_a: assert property (!st_reg.irq_cfg[CCSC_CFG_BDEAD_EN] && !st_reg.evt_stat[CCSC_CFG_BDEAD_EN]
        |=> !st_reg.evt_stat[CCSC_CFG_BDEAD_EN])
        else $error("battery dead status set while disabled");

    rdy_event_a: assert property (evt[CCSC_CFG_RDY_EN] && st_reg.irq_cfg[CCSC_CFG_RDY_EN]
        |=> st_reg.evt_stat[CCSC_CFG_RDY_EN])
        else $error("ready rising edge not latched");

    warn_event_a: assert property (evt[CCSC_CFG_BWARN_EN] && st_reg.irq_cfg[CCSC_CFG_BWARN_EN]
        |=> st_reg.evt_stat[CCSC_CFG_BWARN_EN])
        else $error("battery warning not latched");

    dead_event_a: assert property (evt[CCSC_CFG_BDEAD_EN] && st_reg.irq_cfg[CCSC_CFG_BDEAD_EN]
        |=> st_reg.evt_stat[CCSC_CFG_BDEAD_EN])
        else $error("battery dead not latched");

    irq_route_a: assert property (interrupt_request_line
        == $past(st_reg.irq_cfg[7:CCSC_CFG_ROUTE_LSB]))
        else $error("interrupt line select lags config");

    irq_masked_a: assert property ((st_reg.evt_stat & st_reg.evt_mask) == 4'h0
        |=> !csc_irq)
        else $error("interrupt high with nothing unmasked");

    io_win1_a: assert property (io_rsp.hit && io_rsp.win
        |-> io_rsp.wide == $past(st_reg.io_ctrl[CCSC_IOC_W1_WIDE]))
        else $error("window 1 width does not follow io control");

    io_miss_a: assert property (!io_rsp.hit
        |-> !io_rsp.win && !io_rsp.wide)
        else $error("window or width shown on a miss");

    above_stop_a: assert property (io_req.req && io_req.addr > p0 && io_req.addr > p1
        |=> !io_rsp.hit)
        else $error("hit above both window stops");

    win1_only_a: assert property (io_req.req && st_reg.io_ctrl[CCSC_IOC_MAP_EN] && io_req.addr == s1
        && s1 <= p1 && !(io_req.addr >= s0 && io_req.addr <= p0) |=> io_rsp.hit && io_rsp.win)
        else $error("window 1 hit not reported as window 1");

    win0_prio_a: assert property (io_req.req && st_reg.io_ctrl[CCSC_IOC_MAP_EN]
        && io_req.addr >= s0 && io_req.addr <= p0 |=> io_rsp.hit && !io_rsp.win)
        else $error("window 0 hit lost or misreported");

endmodule // ccsc_regs

`default_nettype wire

/* tb/ccsc_card_model.sv */
// card model: drives the socket status pins from bench commands
`timescale 1ns/1ps
`default_nettype none

module ccsc_card_model (
    // clock
    input  wire logic       sys_clk,
    // bench commands: 3 present, 2 ready, 1 battery warn, 0 battery dead
    input  wire logic [3:0] cmd,
    // socket pins
    output var logic        card_detect_first_n,
    output var logic        card_detect_second_n,
    output var logic        card_ready,
    output var logic        card_batt_warn,
    output var logic        card_batt_dead
);
    initial begin
        card_detect_first_n  = 1'b1;
        card_detect_second_n = 1'b1;
        card_ready           = 1'b0;
        card_batt_warn       = 1'b0;
        card_batt_dead       = 1'b0;
    end

    // second detect contact meets a cycle later, as a real insertion skews
    always @(posedge sys_clk) begin
        card_detect_first_n  <= ~cmd[3];
        card_detect_second_n <= card_detect_first_n;
        card_ready           <= cmd[2];
        card_batt_warn       <= cmd[1];
        card_batt_dead       <= cmd[0];
    end
endmodule // ccsc_card_model

`default_nettype wire

/* tb/card_csc_irq_and_io_windows_bench.sv */
// self-checking bench for the status change and io window registers
`timescale 1ns/1ps
`default_nettype none

module card_csc_irq_and_io_windows_bench import ccsc_pkg::*;;
    logic         sys_clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         wb_cyc = 1'b0;
    logic         wb_stb = 1'b0;
    logic         wb_we = 1'b0;
    logic [7:0]   wb_adr = 8'h00;
    logic [31:0]  wb_dat = 32'h0000_0000;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic [3:0]   cmd = 4'h0;
    logic         cd1_n;
    logic         cd2_n;
    logic         rdy;
    logic         bwarn;
    logic         bdead;
    logic         csc_irq;
    logic [3:0]   irq_line;
    ccsc_io_req_t io_req = '0;
    ccsc_io_rsp_t io_rsp;
    int           n_errors = 0;
    int           compares = 0;

    always #2 sys_clk = ~sys_clk;

    ccsc_regs ccsc_regs_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .card_detect_first_n(cd1_n),
        .card_detect_second_n(cd2_n), .card_ready(rdy), .card_batt_warn(bwarn),
        .card_batt_dead(bdead), .csc_irq(csc_irq), .interrupt_request_line(irq_line),
        .io_req(io_req), .io_rsp(io_rsp));

    ccsc_card_model ccsc_card_model_inst (
        .sys_clk(sys_clk), .cmd(cmd), .card_detect_first_n(cd1_n),
        .card_detect_second_n(cd2_n), .card_ready(rdy), .card_batt_warn(bwarn),
        .card_batt_dead(bdead));

    task automatic test_done();
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // request rises just after an edge and stands until the edge that samples ack high
    task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h00_0000, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        chk("wb_ack_o", 16'h0001, 16'(wb_ack_o));
        if (wb_ack_o !== 1'b1)
            test_done();
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
        // outputs that follow a write move one edge later; look once they settle
        @(negedge sys_clk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, q);
    endtask

    task automatic rdc(input string nm, input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk(nm, 16'(exp), 16'(q));
    endtask

    task automatic io(input logic [15:0] a, input logic [2:0] exp);
        @(posedge sys_clk);
        io_req <= '{req: 1'b1, addr: a};
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("io_rsp", 16'(exp), 16'(io_rsp));
    endtask

    task automatic pulse(input int k);
        @(posedge sys_clk);
        cmd[k] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        cmd[k] <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic t_reset();
        rdc("irq_cfg", CCSC_IDX_IRQ_CFG, 8'h00);
        for (int i = 7; i < 18; i++)
            rdc("reg_reset", 6'(i), 8'h00);
        wr(6'h20, 8'hFF);
        rdc("unmapped", 6'h20, 8'h00);
    endtask

    task automatic t_route();
        for (int v = 0; v < 16; v += 5) begin
            wr(CCSC_IDX_IRQ_CFG, {4'(v), 4'h0});
            chk("irq_line", 16'(v), 16'(irq_line));
            rdc("irq_cfg", CCSC_IDX_IRQ_CFG, {4'(v), 4'h0});
        end
    endtask

    // events arriving while disabled are lost, so both passes pulse the pin
    task automatic t_events();
        for (int k = 3; k >= 0; k--) begin
            wr(CCSC_IDX_EVT_MASK, 8'h0F);
            wr(CCSC_IDX_IRQ_CFG, 8'h00);
            pulse(k);
            rdc("evt_off", CCSC_IDX_EVT_STAT, 8'h00);
            chk("irq_off", 16'h0000, 16'(csc_irq));
            wr(CCSC_IDX_IRQ_CFG, 8'(1 << k));
            pulse(k);
            rdc("evt_on", CCSC_IDX_EVT_STAT, 8'(1 << k));
            chk("irq_on", 16'h0001, 16'(csc_irq));
            wr(CCSC_IDX_EVT_MASK, 8'h00);
            chk("irq_masked", 16'h0000, 16'(csc_irq));
            wr(CCSC_IDX_EVT_STAT, 8'(1 << k));
            rdc("evt_clr", CCSC_IDX_EVT_STAT, 8'h00);
        end
    endtask

    task automatic t_io();
        logic [7:0] w [8] = '{8'h00, 8'h03, 8'h00, 8'h03, 8'h00, 8'h10, 8'hFF, 8'h10};
        for (int i = 0; i < 8; i++)
            wr(6'(8 + i), w[i]);
        for (int i = 0; i < 8; i++)
            rdc("win_byte", 6'(8 + i), w[i]);
        wr(CCSC_IDX_IO_CTRL, 8'h02);
        io(16'h0300, 3'b000);
        wr(CCSC_IDX_IO_CTRL, 8'h82);
        rdc("io_ctrl", CCSC_IDX_IO_CTRL, 8'h82);
        io(16'h0300, 3'b100);
        io(16'h02FF, 3'b000);
        io(16'h0301, 3'b000);
        io(16'h1000, 3'b111);
        io(16'h10FF, 3'b111);
        io(16'h1100, 3'b000);
        wr(CCSC_IDX_IO_CTRL, 8'h81);
        io(16'h0300, 3'b101);
        io(16'h1000, 3'b110);
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_route();
        t_events();
        t_io();
        test_done();
    end
endmodule // card_csc_irq_and_io_windows_bench

`default_nettype wire
